// ### dv/pin_change_irq_tb.sv
// self-checking bench for the pin-change and external-pin flag block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module pin_change_irq_tb;
    import pin_irq_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, globalIrqEnable = 0, flipExt = 0, rdSeen = 0;
    logic [7:0] addr = '0, wdata = '0, vectorTaken = '0, rdata, irqRequest, m, e;
    logic [7:0] rdataSmall, irqRequestSmall;
    logic [30:0] flip = '0, changePins;
    logic ext_irq_pin;
    logic [7:0] expQ[$];
    logic [7:0] maskAddr [4] = '{ADDR_MASK0, ADDR_MASK1, ADDR_MASK2, ADDR_MASK3};
    int num_errors = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    pin_change_irq #(.LARGE(1'b1)) u_pin_change_irq(.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_irq_pin(ext_irq_pin), .changePins(changePins),
        .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken), .irqRequest(irqRequest));
    // small build shares every input so its own assertions see groups 2 and 3 move
    pin_change_irq #(.LARGE(1'b0)) u_pin_change_irq_small(.clk(clk), .rst_n(rst_n), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdataSmall), .ext_irq_pin(ext_irq_pin),
        .changePins(changePins), .globalIrqEnable(globalIrqEnable), .vectorTaken(vectorTaken),
        .irqRequest(irqRequestSmall));
    pin_source u_src(.clk(clk), .flip(flip), .flipExt(flipExt), .changePins(changePins),
        .ext_irq_pin(ext_irq_pin));
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        expQ.push_back(x);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // index 31 stands for the external pin; wait covers sync plus flag latency
    task automatic toggle(input int i);
        @(posedge clk);
        if (i == 31) flipExt <= 1'b1;
        else flip <= 31'h1 << i;
        @(posedge clk);
        flipExt <= 1'b0;
        flip <= '0;
        repeat (6) @(posedge clk);
    endtask
    task complete_run;
        $display("errors %0d compares %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rdSeen) begin
            e = expQ.pop_front();
            `CHK(rdata, e)
        end
        rdSeen <= rd;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h2e61));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int g = 0; g < 4; g++) rd_reg(maskAddr[g], 8'h00);
        rd_reg(ADDR_FLAGS, 8'h00);
        rd_reg(8'h00, 8'h00);
        for (int g = 0; g < 4; g++) begin
            m = 8'($urandom());
            wr_reg(maskAddr[g], m);
            rd_reg(maskAddr[g], (g == 3) ? (m & MASK3_IMPL) : m);
        end
        globalIrqEnable <= 1'b1;
        for (int g = 0; g < 4; g++) begin
            wr_reg(maskAddr[g], 8'h01);
            toggle(8 * g + 1);
            rd_reg(ADDR_FLAGS, 8'h00);
            toggle(8 * g);
            rd_reg(ADDR_FLAGS, 8'h10 << g);
            wr_reg(ADDR_ENABLE, 8'h10 << g);
            repeat (3) @(posedge clk);
            `CHK(irqRequest, 8'h10 << g)
            `CHK(irqRequestSmall, (g < 2) ? (8'h10 << g) : 8'h00)
            vectorTaken <= 8'h10 << g;
            @(posedge clk);
            vectorTaken <= '0;
            repeat (3) @(posedge clk);
            `CHK(irqRequest, 8'h00)
            `CHK(irqRequestSmall, 8'h00)
            rd_reg(ADDR_FLAGS, 8'h00);
        end
        wr_reg(ADDR_ENABLE, 8'h00);
        // pin walks 0-1-0-1: any change, falling, rising
        for (int s = 1; s < 4; s++) begin
            wr_reg(ADDR_SENSE, 8'(s));
            toggle(31);
            rd_reg(ADDR_FLAGS, 8'h01);
            wr_reg(ADDR_FLAGS, 8'h00);
            rd_reg(ADDR_FLAGS, 8'h01);
            wr_reg(ADDR_FLAGS, 8'h0F);
            rd_reg(ADDR_FLAGS, 8'h00);
        end
        toggle(31);
        rd_reg(ADDR_FLAGS, 8'h00);
        toggle(31);
        wr_reg(ADDR_SENSE, 8'h00);
        rd_reg(ADDR_FLAGS, 8'h00);
        wr_reg(ADDR_ENABLE, 8'h01);
        toggle(31);
        `CHK(irqRequest, 8'h01)
        rd_reg(ADDR_FLAGS, 8'h00);
        globalIrqEnable <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(irqRequest, 8'h00)
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule

// ### dv/pin_source.sv
// far-side model: interrupt source pins that flip when the bench asks
`timescale 1ns/1ps
module pin_source (
    input wire logic clk,
    input wire logic [30:0] flip,
    input wire logic flipExt,
    output logic [30:0] changePins = '0,
    output logic ext_irq_pin = 1'b0
);
    // pins are board levels, so device reset leaves them alone
    always @(posedge clk) begin
        changePins <= changePins ^ flip;
        ext_irq_pin <= ext_irq_pin ^ flipExt;
    end
endmodule

// ### rtl/change_detect.sv
// per-bit toggle, rising and falling edge detection on synchronised levels
`timescale 1ns/1ps
module change_detect #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] toggled,
    output logic [WIDTH-1:0] rose,
    output logic [WIDTH-1:0] fell
);
    logic [WIDTH-1:0] prev_ff;
    logic primed_ff;

    // no edge reported on the first cycle after reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_ff <= '0;
            primed_ff <= 1'b0;
        end else begin
            prev_ff <= level;
            primed_ff <= 1'b1;
        end
    end

    assign toggled = primed_ff ? (level ^ prev_ff) : '0;
    assign rose = toggled & level;
    assign fell = toggled & ~level;
endmodule

// ### rtl/pin_change_irq.sv
// flag, mask and request logic for one external pin and four pin-change groups
`timescale 1ns/1ps
module pin_change_irq
    import pin_irq_pkg::*;
#(
    parameter bit LARGE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic ext_irq_pin,
    input wire logic [30:0] changePins,
    input wire logic globalIrqEnable,
    input wire logic [7:0] vectorTaken,
    output logic [7:0] irqRequest
);
    if (LARGE !== 1'b0 && LARGE !== 1'b1) begin : g_badParam
        $error("LARGE must be 0 or 1");
    end

    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] enable_ff;
    logic [1:0] sense_ff;
    pin_masks_t masks_ff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic [7:0] req_ff;
    logic [7:0] nxt_req;

    wire [SYNC_W-1:0] pinSync;
    wire [SYNC_W-1:0] pinToggled;
    wire [SYNC_W-1:0] pinRose;
    wire [SYNC_W-1:0] pinFell;
    wire [7:0] implMask = LARGE ? FLAGS_IMPL_LARGE : FLAGS_IMPL_SMALL;

    // pins are asynchronous, so two flops before any detection
    pin_sync #(.WIDTH(SYNC_W)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn({ext_irq_pin, changePins}),
        .syncOut(pinSync)
    );

    change_detect #(.WIDTH(SYNC_W)) u_edges (
        .clk(clk),
        .rst_n(rst_n),
        .level(pinSync),
        .toggled(pinToggled),
        .rose(pinRose),
        .fell(pinFell)
    );

    // register decode
    wire wrFlags = wr && (addr == ADDR_FLAGS);
    wire wrEnable = wr && (addr == ADDR_ENABLE);
    wire wrSense = wr && (addr == ADDR_SENSE);
    wire wrMask0 = wr && (addr == ADDR_MASK0);
    wire wrMask1 = wr && (addr == ADDR_MASK1);
    wire wrMask2 = wr && (addr == ADDR_MASK2) && LARGE;
    wire wrMask3 = wr && (addr == ADDR_MASK3) && LARGE;
    wire senseLow = (sense_t'(sense_ff) == SENSE_LOW);

    wire setG0 = |(pinToggled[7:0] & masks_ff.grp0);
    wire setG1 = |(pinToggled[15:8] & masks_ff.grp1);
    wire setG2 = LARGE && |(pinToggled[23:16] & masks_ff.grp2);
    wire setG3 = LARGE && |(pinToggled[30:24] & masks_ff.grp3[6:0]);

    wire setExt = (sense_t'(sense_ff) == SENSE_ANY && pinToggled[EXT_SYNC_IDX]) ||
                  (sense_t'(sense_ff) == SENSE_FALL && pinFell[EXT_SYNC_IDX]) ||
                  (sense_t'(sense_ff) == SENSE_RISE && pinRose[EXT_SYNC_IDX]);

    wire [7:0] setVec = {setG3, setG2, setG1, setG0, 3'b000, setExt};
    // clear by vector start or written one
    wire [7:0] clrVec = vectorTaken | (wrFlags ? wdata : REG_RESET);

    // set wins over clear, no enable involved
    always_comb begin
        nxt_flags = ((flags_ff & ~clrVec) | setVec) & implMask;
        if (senseLow) begin
            nxt_flags[BIT_EXT] = 1'b0;
        end
    end

    // request gated by enable and global enable
    always_comb begin
        nxt_req = flags_ff & enable_ff & implMask & {8{globalIrqEnable}};
        // low level requests straight from the pin while held
        nxt_req[BIT_EXT] = enable_ff[BIT_EXT] && globalIrqEnable &&
                           (senseLow ? !pinSync[EXT_SYNC_IDX] : flags_ff[BIT_EXT]);
    end

    // read mux; unmapped addresses read zero
    wire [7:0] rdSel = (addr == ADDR_FLAGS) ? flags_ff :
                       (addr == ADDR_ENABLE) ? enable_ff :
                       (addr == ADDR_SENSE) ? {6'h00, sense_ff} :
                       (addr == ADDR_MASK0) ? masks_ff.grp0 :
                       (addr == ADDR_MASK1) ? masks_ff.grp1 :
                       (addr == ADDR_MASK2) ? masks_ff.grp2 :
                       (addr == ADDR_MASK3) ? masks_ff.grp3 : REG_RESET;
    assign nxt_rdata = rd ? rdSel : REG_RESET;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_ff <= REG_RESET;
            req_ff <= REG_RESET;
            rdata_ff <= REG_RESET;
        end else begin
            flags_ff <= nxt_flags;
            req_ff <= nxt_req;
            rdata_ff <= nxt_rdata;
        end
    end

    // enable, sense and mask registers, unbuilt groups stay zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_ff <= REG_RESET;
            sense_ff <= 2'h0;
            masks_ff <= '0;
        end else begin
            if (wrEnable) enable_ff <= wdata & implMask;
            if (wrSense) sense_ff <= wdata[1:0];
            if (wrMask0) masks_ff.grp0 <= wdata;
            if (wrMask1) masks_ff.grp1 <= wdata;
            if (wrMask2) masks_ff.grp2 <= wdata;
            if (wrMask3) masks_ff.grp3 <= wdata & MASK3_IMPL;
        end
    end

    assign rdata = rdata_ff;
    assign irqRequest = req_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_g3_flag_set: assert property (setG3 |=> flags_ff[BIT_G3])
        else $error("group-3 change did not set flag");
    a_g2_flag_set: assert property (setG2 |=> flags_ff[BIT_G2])
        else $error("group-2 change did not set flag");
    a_g1_pin_set: assert property ((pinToggled[8] && masks_ff.grp1[0]) |=> flags_ff[BIT_G1])
        else $error("group-1 pin change did not set flag");
    a_g0_pin_set: assert property ((pinToggled[0] && masks_ff.grp0[0]) |=> flags_ff[BIT_G0])
        else $error("group-0 pin change did not set flag");
    a_ext_rise_set: assert property ((sense_ff == SENSE_RISE && pinRose[EXT_SYNC_IDX]) |=> flags_ff[BIT_EXT])
        else $error("rising edge did not set external flag");
    a_ext_fall_only: assert property ((sense_ff == SENSE_FALL && !pinFell[EXT_SYNC_IDX] && !flags_ff[BIT_EXT])
        |=> !flags_ff[BIT_EXT])
        else $error("external flag set without falling edge");
    a_req_gated: assert property (irqRequest[BIT_G1] |-> $past(flags_ff[BIT_G1] && enable_ff[BIT_G1] &&
        globalIrqEnable))
        else $error("group-1 request without flag and enables");
    a_req_raised: assert property ((flags_ff[BIT_G0] && enable_ff[BIT_G0] && globalIrqEnable) |=>
        irqRequest[BIT_G0])
        else $error("group-0 request missing");
    a_vector_clear: assert property ((vectorTaken[BIT_G1] && !setG1) |=> !flags_ff[BIT_G1])
        else $error("vector start did not clear flag");
    a_w1c_clear: assert property ((wrFlags && wdata[BIT_G0] && !setG0) |=> !flags_ff[BIT_G0])
        else $error("write one did not clear flag");
    a_zero_keeps: assert property ((wrFlags && !wdata[BIT_G0] && !vectorTaken[BIT_G0] && flags_ff[BIT_G0])
        |=> flags_ff[BIT_G0])
        else $error("write zero cleared flag");
    a_level_clear: assert property ((sense_ff == SENSE_LOW) |=> !flags_ff[BIT_EXT])
        else $error("external flag set in low-level mode");
    a_level_req: assert property ((sense_ff == SENSE_LOW && enable_ff[BIT_EXT] && globalIrqEnable &&
        !pinSync[EXT_SYNC_IDX]) |=> irqRequest[BIT_EXT])
        else $error("low level did not request");
    a_small_zero: assert property (!LARGE |-> (flags_ff[BIT_G3:BIT_G2] == 2'b00 &&
        masks_ff.grp2 == 8'h00))
        else $error("small build shows group 2 or 3");
    a_mask3_top: assert property (masks_ff.grp3[7] == 1'b0)
        else $error("group-3 mask bit 7 set");
    a_mask2_write: assert property ((wrMask2) |=> masks_ff.grp2 == $past(wdata))
        else $error("group-2 mask write lost");
    a_mask1_write: assert property ((wrMask1) |=> masks_ff.grp1 == $past(wdata))
        else $error("group-1 mask write lost");
    a_mask0_block: assert property ((masks_ff.grp0 == 8'h00 && !flags_ff[BIT_G0]) |=> !flags_ff[BIT_G0])
        else $error("masked group-0 pin set flag");
    a_reserved_zero: assert property (flags_ff[3:1] == 3'b000)
        else $error("reserved flag bits set");
    a_flags_free: assert property ((setG0 && enable_ff[BIT_G0] == 1'b0) |=> flags_ff[BIT_G0])
        else $error("flag needed enable to set");
    a_read_data: assert property (rd |=> rdata == $past(rdSel))
        else $error("read data wrong");
    a_read_idle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside read slot");
    a_enable_resv: assert property (enable_ff[3:1] == 3'b000)
        else $error("reserved enable bits set");
    a_mask3_write: assert property (wrMask3 |=> masks_ff.grp3 == ($past(wdata) & MASK3_IMPL))
        else $error("group-3 mask write lost");
    a_ext_any_set: assert property ((sense_ff == SENSE_ANY && pinToggled[EXT_SYNC_IDX]) |=> flags_ff[BIT_EXT])
        else $error("pin change did not set external flag");
    a_global_off: assert property (!globalIrqEnable |=> irqRequest == 8'h00)
        else $error("request while global enable off");
    a_mask2_block: assert property ((masks_ff.grp2 == 8'h00 && !flags_ff[BIT_G2]) |=> !flags_ff[BIT_G2])
        else $error("masked group-2 pin set flag");

    c_g0_flag: cover property (setG0 ##1 flags_ff[BIT_G0]);
    c_ext_req: cover property (irqRequest[BIT_EXT]);
    c_w1c: cover property (flags_ff[BIT_G1] ##1 (wrFlags && wdata[BIT_G1]) ##1 !flags_ff[BIT_G1]);
    c_set_over_clear: cover property (setG0 && vectorTaken[BIT_G0]);
    c_level_hold: cover property (senseLow && irqRequest[BIT_EXT]);
endmodule

// ### rtl/pin_irq_pkg.sv
// shared constants and types for the pin-change and external-pin interrupt flag block
package pin_irq_pkg;
    localparam logic [7:0] ADDR_FLAGS = 8'h3C;
    localparam logic [7:0] ADDR_ENABLE = 8'h3D;
    localparam logic [7:0] ADDR_SENSE = 8'h69;
    localparam logic [7:0] ADDR_MASK0 = 8'h6B;
    localparam logic [7:0] ADDR_MASK1 = 8'h6C;
    localparam logic [7:0] ADDR_MASK2 = 8'h6D;
    localparam logic [7:0] ADDR_MASK3 = 8'h73;
    localparam int BIT_EXT = 0;
    localparam int BIT_G0 = 4;
    localparam int BIT_G1 = 5;
    localparam int BIT_G2 = 6;
    localparam int BIT_G3 = 7;
    localparam int EXT_SYNC_IDX = 31;
    localparam int SYNC_W = 32;
    localparam logic [7:0] FLAGS_IMPL_LARGE = 8'hF1;
    localparam logic [7:0] FLAGS_IMPL_SMALL = 8'h31;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK3_IMPL = 8'h7F;
    typedef enum logic [1:0] {
        SENSE_LOW = 2'b00,
        SENSE_ANY = 2'b01,
        SENSE_FALL = 2'b10,
        SENSE_RISE = 2'b11
    } sense_t;
    typedef struct packed {
        logic [7:0] grp3;
        logic [7:0] grp2;
        logic [7:0] grp1;
        logic [7:0] grp0;
    } pin_masks_t;
endpackage

// ### rtl/pin_sync.sv
// two-flop synchroniser for asynchronous input pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= asyncIn;
            sync_ff <= meta_ff;
        end
    end

    assign syncOut = sync_ff;
endmodule
